/* File: rtl/tws_dev.sv */
`timescale 1ns/10ps
// Contract
// - Answer only to the fixed address
// - One protocol for standard and fast rates
// - Start is data falling while clock high
// - Stop is data rising, releases, idles
// - Data changes only while clock low
// - Host sends address then direction bit
// - Acknowledge only a matching address on ninth
// - Receiver acknowledges every byte, unlimited bytes; the host refuses the one byte it reads
// - Host alone makes clock and conditions
// - After stop, ignore until start plus match
// - Host stops an abandoned transfer
// - Unmapped register reads return all ones
// - Registers survive without any reset
// - Data pin is open drain, idle released
module tws_dev (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  tws_if.dev bus,
  input wire logic [7:0] stat_i,
  output logic [7:0] ctrl0_o,
  output logic wr_stb_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK
  } tws_dev_st_e;

  // rate independent sampling
  // Synchronisers, two flops each
  logic [1:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  // Protocol state
  tws_dev_st_e st_q, st_d;
  logic [3:0] bit_q, bit_d; // Bit counter in a byte
  logic [7:0] sh_q, sh_d; // Shift register
  logic [7:0] ptr_q, ptr_d; // Register pointer
  logic ptr_ok_q, ptr_ok_d; // Pointer byte received
  logic pull_q, pull_d; // Pull data line low
  logic stb_q, stb_d;
  logic [7:0] wa_q, wa_d, wd_q, wd_d;
  // Register storage; no reset so contents survive
  localparam int TWS_NREG_L = tws_pkg::TWS_NREG;
  logic [7:0] mem_q [TWS_NREG_L];

  // Read with all-ones outside the map
  function automatic logic [7:0] rd(input logic [7:0] a);
    if (a > tws_pkg::TWS_REG_LAST) begin
      return tws_pkg::TWS_UNMAPPED;
    end
    return (a == 8'h00) ? stat_i : mem_q[a[3:0]];
  endfunction

  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  wire start = scl & scl_p_q & sda_p_q & ~sda;
  wire stop = scl & scl_p_q & ~sda_p_q & sda;

  // Next state of protocol engine
  always_comb begin
    scl_s_d = {scl_s_q[0], bus.scl};
    sda_s_d = {sda_s_q[0], bus.sda};
    scl_p_d = scl;
    sda_p_d = sda;
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ptr_ok_d = ptr_ok_q;
    pull_d = pull_q;
    stb_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    if (start) begin
      st_d = ST_ADDR;
      bit_d = 4'h0;
      pull_d = 1'b0;
      ptr_ok_d = 1'b0;
    end else if (stop) begin
      st_d = ST_IDLE;
      pull_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: pull_d = 1'b0;
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] == tws_pkg::TWS_ADDR) begin
                pull_d = 1'b1;
                st_d = ST_AACK;
              end else begin
                st_d = ST_IDLE;
              end
            end else begin
              pull_d = 1'b1;
              st_d = ST_RACK;
              if (!ptr_ok_q) begin
                ptr_d = sh_q;
                ptr_ok_d = 1'b1;
              end else begin
                stb_d = 1'b1;
                wa_d = ptr_q;
                wd_d = sh_q;
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        ST_AACK, ST_RACK: begin
          if (scl_fall) begin
            if (st_q == ST_AACK && sh_q[0] == tws_pkg::TWS_DIR_READ) begin
              sh_d = rd(ptr_q);
              // First bit out is the top of the fetched byte
              pull_d = ~sh_d[7];
              ptr_d = ptr_q + 8'h01;
              bit_d = 4'h1;
              st_d = ST_TX;
            end else begin
              pull_d = 1'b0;
              st_d = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              pull_d = 1'b0;
              st_d = ST_TACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b1};
              pull_d = ~sh_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            st_d = sda ? ST_IDLE : ST_TACK;
            bit_d = 4'h0;
          end else if (scl_fall) begin
            sh_d = rd(ptr_q);
            pull_d = ~sh_d[7];
            ptr_d = ptr_q + 8'h01;
            bit_d = 4'h1;
            st_d = ST_TX;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // Registered protocol state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      ptr_ok_q <= 1'b0;
      pull_q <= 1'b0;
      stb_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ptr_ok_q <= ptr_ok_d;
      pull_q <= pull_d;
      stb_q <= stb_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (stb_q && wa_q <= tws_pkg::TWS_REG_LAST) begin
      mem_q[wa_q[3:0]] <= wd_q;
    end
  end

  // open drain, enable low while pulling
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe_n = ~pull_q;
  assign wr_stb_o = stb_q;
  assign wr_addr_o = wa_q;
  assign wr_data_o = wd_q;
  assign ctrl0_o = mem_q[1];
endmodule

/* File: rtl/tws_host.sv */
`timescale 1ns/10ps
// Host end: makes clock, start, address, data and stop
module tws_host (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  tws_if.host bus,
  input wire logic go_i, // Pulse, begins a transfer
  input wire logic rd_i, // Direction of the transfer
  input wire logic [7:0] reg_i, // Register pointer
  input wire logic [7:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rdata_o
);
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BYTE, H_RSTART, H_STOP, H_END
  } tws_host_st_e;

  localparam int HALF = tws_pkg::TWS_HALF_CYC;
  tws_host_st_e st_q, st_d;
  logic [1:0] sda_s_q, sda_s_d; // Data line synchroniser
  logic [7:0] cnt_q, cnt_d; // Half period timer
  logic [4:0] ph_q, ph_d; // Half phase in byte, 18 per byte
  logic [1:0] byte_q, byte_d; // Byte index in transfer
  logic [7:0] sh_q, sh_d;
  logic rd_q, rd_d, scl_q, scl_d, sda_q, sda_d;
  logic busy_q, busy_d, done_q, done_d, nack_q, nack_d;
  logic [7:0] rdat_q, rdat_d, reg_q, reg_d, wd_q, wd_d;
  wire tick = (cnt_q == 8'(HALF - 1));
  wire sda_in = sda_s_q[1];

  // address then direction
  // Byte to send for an index
  function automatic logic [7:0] tx_byte(input logic [1:0] i,
    input logic r);
    case (i)
      2'd0: return {tws_pkg::TWS_ADDR, tws_pkg::TWS_DIR_WRITE};
      2'd1: return reg_q;
      2'd2: return r ? {tws_pkg::TWS_ADDR, tws_pkg::TWS_DIR_READ} : wd_q;
      default: return 8'hff;
    endcase
  endfunction

  // Next state of the bus master
  always_comb begin
    sda_s_d = {sda_s_q[0], bus.sda};
    st_d = st_q;
    cnt_d = tick ? 8'h00 : cnt_q + 8'h01;
    ph_d = ph_q;
    byte_d = byte_q;
    sh_d = sh_q;
    rd_d = rd_q;
    scl_d = scl_q;
    sda_d = sda_q;
    busy_d = busy_q;
    done_d = 1'b0;
    nack_d = nack_q;
    rdat_d = rdat_q;
    reg_d = reg_q;
    wd_d = wd_q;
    case (st_q)
      H_IDLE: begin
        if (go_i) begin
          busy_d = 1'b1;
          rd_d = rd_i;
          reg_d = reg_i;
          wd_d = wdata_i;
          nack_d = 1'b0;
          byte_d = 2'd0;
          cnt_d = 8'h00;
          st_d = H_START;
        end
      end
      H_START: if (tick) begin
        // Start: data falls while clock high
        sda_d = 1'b0;
        ph_d = 5'd0;
        sh_d = tx_byte(byte_q, rd_q);
        st_d = H_BYTE;
      end
      H_BYTE: if (tick) begin
        ph_d = ph_q + 5'd1;
        if (!ph_q[0]) begin
          // Clock low half: set data
          scl_d = 1'b0;
          if (ph_q < 5'd16) begin
            sda_d = (byte_q == 2'd3) ? 1'b1 : sh_q[7];
          end else begin
            // Refusing the last read byte makes the device let go
            // of data before the stop, else it could hold it low
            sda_d = 1'b1;
          end
        end else begin
          scl_d = 1'b1;
          if (ph_q < 5'd16) begin
            sh_d = {sh_q[6:0], sda_in};
          end else if (byte_q != 2'd3 && sda_in) begin
            nack_d = 1'b1;
            st_d = H_STOP;
            ph_d = 5'd0;
          end else if (byte_q == 2'd3 || (byte_q == 2'd2 && !rd_q)) begin
            if (byte_q == 2'd3) begin
              rdat_d = sh_q;
            end
            st_d = H_STOP;
            ph_d = 5'd0;
          end else if (byte_q == 2'd2) begin
            byte_d = 2'd3;
            sh_d = 8'hff;
            ph_d = 5'd0;
          end else if (byte_q == 2'd1 && rd_q) begin
            byte_d = 2'd2;
            st_d = H_RSTART;
            ph_d = 5'd0;
          end else begin
            byte_d = byte_q + 2'd1;
            sh_d = tx_byte(byte_q + 2'd1, rd_q);
            ph_d = 5'd0;
          end
        end
      end
      H_RSTART: if (tick) begin
        // Repeated start: release data, raise clock, pull data
        ph_d = ph_q + 5'd1;
        case (ph_q)
          5'd0: begin
            scl_d = 1'b0;
            sda_d = 1'b1;
          end
          5'd1: scl_d = 1'b1;
          default: begin
            sda_d = 1'b0;
            sh_d = tx_byte(2'd2, rd_q);
            ph_d = 5'd0;
            st_d = H_BYTE;
          end
        endcase
      end
      H_STOP: if (tick) begin
        // stop closes every transfer
        // Stop: data rises while clock high
        ph_d = ph_q + 5'd1;
        case (ph_q)
          5'd0: begin
            scl_d = 1'b0;
            sda_d = 1'b0;
          end
          5'd1: scl_d = 1'b1;
          default: begin
            sda_d = 1'b1;
            st_d = H_END;
          end
        endcase
      end
      H_END: if (tick) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        st_d = H_IDLE;
      end
      default: st_d = H_IDLE;
    endcase
  end

  // Registered master state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_s_q <= 2'h3;
      st_q <= H_IDLE;
      cnt_q <= 8'h00;
      ph_q <= 5'd0;
      byte_q <= 2'd0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdat_q <= 8'h00;
      reg_q <= 8'h00;
      wd_q <= 8'h00;
    end else begin
      sda_s_q <= sda_s_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      busy_q <= busy_d;
      done_q <= done_d;
      nack_q <= nack_d;
      rdat_q <= rdat_d;
      reg_q <= reg_d;
      wd_q <= wd_d;
    end
  end

  // host alone drives clock
  // Open drain: only ever pull low
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe_n = scl_q;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe_n = sda_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign nack_o = nack_q;
  assign rdata_o = rdat_q;
endmodule

/* File: rtl/tws_if.sv */
`timescale 1ns/10ps
// Two-wire bus; open-drain, enables are low while a party pulls low
interface tws_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  // Wired-and with pull-ups
  wire scl = scl_oe_n ? 1'b1 : scl_o;
  wire sda = (sda_dev_oe_n ? 1'b1 : sda_dev_o) &
    (sda_host_oe_n ? 1'b1 : sda_host_o);
  modport dev (
    input scl,
    input sda,
    output sda_dev_o,
    output sda_dev_oe_n
  );
  modport host (
    input scl,
    input sda,
    output scl_o,
    output scl_oe_n,
    output sda_host_o,
    output sda_host_oe_n
  );
endinterface

/* File: rtl/tws_pkg.sv */
package tws_pkg;
  // Fixed 7-bit target address, 0xd6 once shifted
  localparam logic [6:0] TWS_ADDR = 7'h6b;
  // Value read back from an unmapped register
  localparam logic [7:0] TWS_UNMAPPED = 8'hff;
  // Direction bit values
  localparam logic TWS_DIR_WRITE = 1'b0;
  localparam logic TWS_DIR_READ = 1'b1;
  // Register file size and the mapped span
  localparam int TWS_NREG = 16;
  localparam logic [7:0] TWS_REG_LAST = 8'h0f;
  // Reference clock and host bus timing
  localparam int TWS_CLK_NS = 40;
  localparam int TWS_SCL_HALF_NS = 1250;
  // Link clock half period in ref clocks, rounded down, at least one
  localparam int TWS_HALF_CYC = (TWS_SCL_HALF_NS / TWS_CLK_NS) < 1 ? 1 :
    (TWS_SCL_HALF_NS / TWS_CLK_NS);
endpackage

/* File: tb/i2c_register_slave_bench.sv */
`timescale 1ns/10ps
// Host and device joined; a second device is clocked by hand
module i2c_register_slave_bench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] reg_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] stat_i = 8'h00;
  logic busy_o, done_o, nack_o, wr_stb_o, ack;
  logic [7:0] rdata_o, ctrl0_o, wr_addr_o, wr_data_o, sa, sd, rq;
  logic [7:0] mem [16]; // Expected register contents
  int n_errors = 0;
  int tests_run = 0;
  tws_if bus();
  tws_if bus_b(); // Hand-driven bus
  tws_host i_tws_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus(bus.host), .go_i(go_i), .rd_i(rd_i), .reg_i(reg_i),
    .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
    .nack_o(nack_o), .rdata_o(rdata_o));
  tws_dev i_tws_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus(bus.dev), .stat_i(stat_i), .ctrl0_o(ctrl0_o),
    .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
  tws_dev i_tws_dev_b (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus(bus_b.dev), .stat_i(8'h00), .ctrl0_o(),
    .wr_stb_o(), .wr_addr_o(), .wr_data_o());
  tws_monitor i_tws_monitor (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .scl(bus.scl), .sda(bus.sda), .sda_dev_o(bus.sda_dev_o),
    .sda_dev_oe_n(bus.sda_dev_oe_n));
  always #20 ref_clk_i = ~ref_clk_i;
  // Last write handed to the register side
  always @(posedge ref_clk_i) begin
    if (wr_stb_o === 1'b1) begin
      sa <= wr_addr_o;
      sd <= wr_data_o;
    end
  end
  // Read value: status at 0, all ones off the map
  function automatic logic [7:0] exp_rd(input logic [7:0] r);
    if (r > tws_pkg::TWS_REG_LAST) return tws_pkg::TWS_UNMAPPED;
    if (r == 8'h00) return stat_i;
    return mem[r[3:0]];
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One transfer through the host end, bounded wait
  task automatic xfer(input logic rd, input logic [7:0] r,
                      input logic [7:0] d);
    int n;
    @(negedge ref_clk_i);
    go_i = 1'b1;
    rd_i = rd;
    reg_i = r;
    wdata_i = d;
    stat_i = 8'($urandom());
    @(negedge ref_clk_i);
    go_i = 1'b0;
    chk1(busy_o, 1'b1);
    n = 0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk1(done_o, 1'b1);
    chk1(nack_o, 1'b0);
    if (rd) begin
      chk8(rdata_o, exp_rd(r));
    end else if (r <= tws_pkg::TWS_REG_LAST && r != 8'h00) begin
      mem[r[3:0]] = d;
      chk8(sa, r);
      chk8(sd, d);
    end
  endtask
  // Link half period of 160 ns
  task automatic half();
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic bb_start();
    bus_b.sda_host_oe_n = 1'b1;
    half();
    bus_b.scl_oe_n = 1'b1;
    half();
    bus_b.sda_host_oe_n = 1'b0;
    half();
    bus_b.scl_oe_n = 1'b0;
    half();
  endtask
  // Eight bits MSB first, then the acknowledge slot
  // m is the slot value the hand host gives, q the byte seen on the line
  task automatic bb_byte(input logic [7:0] b, input logic m,
                         output logic a, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bus_b.sda_host_oe_n = b[i];
      half();
      bus_b.scl_oe_n = 1'b1;
      half();
      q[i] = bus_b.sda;
      bus_b.scl_oe_n = 1'b0;
      @(negedge ref_clk_i);
    end
    bus_b.sda_host_oe_n = m;
    half();
    bus_b.scl_oe_n = 1'b1;
    half();
    a = bus_b.sda;
    bus_b.scl_oe_n = 1'b0;
    half();
  endtask
  task automatic bb_stop();
    bus_b.sda_host_oe_n = 1'b0;
    half();
    bus_b.scl_oe_n = 1'b1;
    half();
    bus_b.sda_host_oe_n = 1'b1;
    half();
  endtask
  initial begin
    bus_b.scl_o = 1'b0;
    bus_b.scl_oe_n = 1'b1;
    bus_b.sda_host_o = 1'b0;
    bus_b.sda_host_oe_n = 1'b1;
    void'($urandom(32'hda53));
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    // Fill every writable register first
    for (int r = 1; r < 16; r++) xfer(1'b0, 8'(r), 8'($urandom()));
    xfer(1'b1, 8'hff, 8'h00);
    xfer(1'b0, 8'h00, 8'h33);
    xfer(1'b1, 8'h00, 8'h00);
    for (int k = 0; k < 10; k++)
      xfer(1'($urandom()), 8'($urandom_range(19, 0)), 8'($urandom()));
    chk8(ctrl0_o, mem[1]);
    // Contents must ride through a reset
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    xfer(1'b1, 8'h01, 8'h00);
    chk8(ctrl0_o, mem[1]);
    // Hand-driven bus: wrong address, restart, no start
    bb_start();
    bb_byte({tws_pkg::TWS_ADDR ^ 7'h01, 1'b0}, 1'b1, ack, rq);
    chk1(ack, 1'b1);
    bb_start();
    bb_byte({tws_pkg::TWS_ADDR, tws_pkg::TWS_DIR_WRITE}, 1'b1, ack, rq);
    chk1(ack, 1'b0);
    bb_byte(8'h20, 1'b1, ack, rq);
    chk1(ack, 1'b0);
    // Repeated start, two bytes read off the map, first one acked
    bb_start();
    bb_byte({tws_pkg::TWS_ADDR, tws_pkg::TWS_DIR_READ}, 1'b1, ack, rq);
    chk1(ack, 1'b0);
    bb_byte(8'hff, 1'b0, ack, rq);
    chk8(rq, exp_rd(8'h20));
    bb_byte(8'hff, 1'b1, ack, rq);
    chk8(rq, exp_rd(8'h21));
    bb_stop();
    bb_byte({tws_pkg::TWS_ADDR, tws_pkg::TWS_DIR_WRITE}, 1'b1, ack, rq);
    chk1(ack, 1'b1);
    wrap_up();
  end
  // Cut a hang short
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_errors++;
    wrap_up();
  end
endmodule

/* File: tb/tws_monitor.sv */
`timescale 1ns/10ps
// Watches the shared bus between host end and device end
module tws_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  logic scl_q, sda_q, fr_q, fr_d, first_q, first_d, rd_q, rd_d;
  logic [3:0] cnt_q, cnt_d; // Clock rises in this byte
  logic [7:0] sh_q, sh_d; // Bits of this byte
  logic rise_w, start_w, stop_w;
  // Framing seen at the reference clock
  always_comb begin
    rise_w = scl && !scl_q;
    start_w = scl && scl_q && sda_q && !sda;
    stop_w = scl && scl_q && !sda_q && sda;
    fr_d = fr_q;
    cnt_d = cnt_q;
    first_d = first_q;
    rd_d = rd_q;
    sh_d = sh_q;
    if (start_w) begin
      fr_d = 1'b1;
      cnt_d = 4'h0;
      first_d = 1'b1;
    end else if (stop_w) begin
      fr_d = 1'b0;
      cnt_d = 4'h0;
    end else if (rise_w && fr_q) begin
      // Ninth rise closes the byte
      if (cnt_q == 4'h8) begin
        cnt_d = 4'h0;
        first_d = 1'b0;
        if (first_q) rd_d = sh_q[0];
      end else begin
        cnt_d = cnt_q + 4'h1;
        sh_d = {sh_q[6:0], sda};
      end
    end
  end
  // Registers only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      fr_q <= 1'b0;
      cnt_q <= 4'h0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      fr_q <= fr_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      rd_q <= rd_d;
      sh_q <= sh_d;
    end
  end
  sequence s_nine;
    rise_w && cnt_q == 4'h8;
  endsequence
  sequence s_hit;
    s_nine ##0 first_q && sh_q[7:1] == tws_pkg::TWS_ADDR;
  endsequence
  AST_OPEN_DRAIN: assert property (!sda_dev_oe_n |-> !sda_dev_o)
    else $error("device drove data high");
  AST_IDLE_FREE: assert property (!fr_q |-> sda_dev_oe_n)
    else $error("device pulls data while idle");
  AST_HIGH_STEADY: assert property (scl && scl_q |-> $stable(sda_dev_oe_n))
    else $error("device data moved in clock high");
  AST_ADDR_QUIET: assert property (fr_q && first_q && cnt_q < 4'h8 |-> sda_dev_oe_n)
    else $error("device pulls during address");
  AST_ADDR_ACK: assert property (s_hit |-> (!sda_dev_oe_n) [*8])
    else $error("address acknowledge missing");
  AST_WR_ACK: assert property (s_nine ##0 !first_q && !rd_q |-> !sda)
    else $error("written byte not acknowledged");
  AST_RD_FREE: assert property (s_nine ##0 !first_q && rd_q |-> sda_dev_oe_n)
    else $error("device kept data in host ack");
  AST_STOP_FREE: assert property (stop_w |=> sda_dev_oe_n [*8])
    else $error("device pulls after stop");
endmodule
